// File: wdt_top.v
// Functional notes
// - Reload write loads counter immediately
// - Reload of zero raises interrupt at once
// - Count register reads live counter
// - Control writes ignored once irq enabled
// - Control bit 1 gates reset output
// - Irq enable sticky until hardware reset
// - Clear write clears irq, reloads counter
// - Clear register write-only, reads as zero
// - Raw status bit 0 shows unmasked irq
// - Masked status is raw AND enable
// - Unlock key enables register writes
// - Other lock values re-impose lock
// - Lock read returns lock state
// - Stall bit halts counting during debug
// - First zero raises irq and reloads
// - Second zero with irq pending resets
// - Reload write keeps pending irq
// - Enabling irq restarts from reload value
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wdt_regs.vh"

module wdt_top #(
  parameter [31:0] PID0 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] PID1 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] PID2 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] PID3 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] PID4 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] PID5 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] PID6 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] PID7 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] CID0 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] CID1 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] CID2 = 32'h00000000,  // Arbitrary identity value
  parameter [31:0] CID3 = 32'h00000000   // Arbitrary identity value
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Debug halt from processor (asynchronous pin)
  input  wire        cpu_halted,
  // Watchdog outputs
  output reg         watchdog_irq,
  output reg         watchdog_reset
);

  // ****************************************
  // Behaviour overview
  // ****************************************
  // Counter runs only once the irq enable bit is set
  // Irq enable is sticky, so the counter cannot be stopped by software
  // Only a hardware reset clears irq enable and the reset output
  // First time-out sets the raw flag and reloads the counter
  // Second time-out with raw flag still set may drive system reset
  // Reset output stays high until the next hardware reset
  // Interrupt output is raw flag gated by irq enable, one cycle later, except a clear write drops it on the same edge
  // Masked status read uses the same gating, without the delay
  // Clear write drops the raw flag and restarts from the reload value
  // Reload write restarts the counter but never clears the raw flag
  // Reload of zero sets the raw flag on the same edge
  // Enabling the interrupt restarts the counter from the reload value
  //
  // Same-edge priority on the counter:
  //   reload write, then clear write, then enable, then counting
  // A reload write on a time-out edge hides that time-out
  // A clear write on a time-out edge wins over the time-out
  // Hazard: software that keeps clearing never reaches second time-out
  //
  // Lock behaviour:
  //   lock register is reachable whatever the lock state
  //   the unlock key opens every other register for writes
  //   any other lock value closes them again
  //   locked writes still answer OKAY, they just have no effect
  //   lock reads return the state, never the written word
  //
  // Control register:
  //   writable while irq enable is still zero
  //   needs the low byte strobe to take effect
  //   reset enable must be set in the same write as irq enable,
  //   since that write also loads bit 1 and later writes are dropped
  //
  // Debug stall:
  //   stall bit needs the second byte strobe
  //   halt pin is asynchronous, so it is synchronised first
  //   counting stops two to three cycles after halt rises
  //   counting resumes two to three cycles after halt falls
  //   the count value is kept across the stall
  //
  // Bus behaviour:
  //   address and data may arrive in either order
  //   the write response follows one cycle after both are held
  //   a new write is taken only after the response handshake
  //   reads answer one cycle after the address is taken
  //   read data is captured at the address handshake
  //   unmapped or read-only write addresses answer SLVERR
  //   unmapped read addresses answer SLVERR with zero data
  //   address bits 1 and 0 are ignored
  //
  // Limitations:
  //   identity registers are fixed parameters, not configurable
  //   the clear register reads as zero, software must not rely on it
  //   count reads are a snapshot, the counter moves on meanwhile

  // ****************************************
  // State
  // ****************************************
  reg [31:0] reload_value;
  reg [31:0] count_value;
  reg        irq_enable;
  reg        reset_output_enable;
  reg        raw_irq;
  reg        stall_enable;
  reg        locked;
  reg        halt_meta;
  reg        halt_sync;
  // Write channel capture
  reg        aw_held;
  reg        w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  wire       wr_fire;
  wire       wr_open;
  wire       running;
  wire       at_zero;
  wire [31:0] strb_mask;
  wire [31:0] reload_merged;
  wire       wr_reload;
  wire       wr_control;
  wire       wr_clear;
  wire       wr_stall;
  wire       wr_lock;
  wire       next_irq_enable;
  reg        wr_hit;
  reg [31:0] rd_word;
  reg        rd_hit;

  // ****************************************
  // Debug halt synchroniser
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end else begin
      halt_meta <= cpu_halted;
      halt_sync <= halt_meta;
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  // Accept address and data in either order, respond after both
  // Each channel ready drops once its item is held
  // Both readies return after the response handshake
  // Register effects land on the edge that raises bvalid
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDT_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  // Lock register always reachable, others only when unlocked
  assign wr_open = wr_fire && !locked;
  assign strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign reload_merged = (w_data & strb_mask) | (reload_value & ~strb_mask);
  assign wr_reload  = wr_open && (aw_addr[11:2] == `WDT_OFF_RELOAD >> 2);
  assign wr_control = wr_open && (aw_addr[11:2] == `WDT_OFF_CONTROL >> 2) && !irq_enable;
  assign wr_clear   = wr_open && (aw_addr[11:2] == `WDT_OFF_IRQ_CLEAR >> 2);
  assign wr_stall   = wr_open && (aw_addr[11:2] == `WDT_OFF_STALL >> 2) && w_strb[1];
  assign wr_lock    = wr_fire && (aw_addr[11:2] == `WDT_OFF_LOCK >> 2);
  assign next_irq_enable = wr_control && w_strb[0] && w_data[`WDT_CTL_IRQ_EN_BIT];

  // Writable address decode
  // Count, status and identity words are read-only
  // Any other address is unmapped
  always @* begin
    case (aw_addr[11:2])
      `WDT_OFF_RELOAD >> 2:    wr_hit = 1'b1;
      `WDT_OFF_CONTROL >> 2:   wr_hit = 1'b1;
      `WDT_OFF_IRQ_CLEAR >> 2: wr_hit = 1'b1;
      `WDT_OFF_STALL >> 2:     wr_hit = 1'b1;
      `WDT_OFF_LOCK >> 2:      wr_hit = 1'b1;
      default:                 wr_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      reload_value        <= `WDT_RELOAD_RESET;
      irq_enable          <= 1'b0;
      reset_output_enable <= 1'b0;
      stall_enable        <= 1'b0;
      locked              <= 1'b0;
    end else begin
      if (wr_reload)
        reload_value <= reload_merged;
      if (wr_control && w_strb[0]) begin
        irq_enable          <= w_data[`WDT_CTL_IRQ_EN_BIT];
        reset_output_enable <= w_data[`WDT_CTL_RST_EN_BIT];
      end
      if (wr_stall)
        stall_enable <= w_data[`WDT_STALL_BIT];
      if (wr_lock)
        locked <= (w_data != `WDT_UNLOCK_KEY);
    end
  end

  // ****************************************
  // Down counter and time-out logic
  // ****************************************
  // Counting gated by enable and synchronised debug halt
  // Stall only applies while the stall bit is set
  assign running = irq_enable && !(stall_enable && halt_sync);
  assign at_zero = (count_value == 32'h00000000);

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_value    <= `WDT_RELOAD_RESET;
      raw_irq        <= 1'b0;
      watchdog_irq   <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      if (wr_reload) begin
        count_value <= reload_merged;
        if (reload_merged == 32'h00000000)
          raw_irq <= 1'b1;
      end else if (wr_clear) begin
        count_value <= reload_value;
        raw_irq     <= 1'b0;
      end else if (next_irq_enable) begin
        count_value <= reload_value;
      end else if (running) begin
        if (at_zero) begin
          count_value <= reload_value;
          if (raw_irq && reset_output_enable)
            watchdog_reset <= 1'b1;
          raw_irq <= 1'b1;
        end else begin
          count_value <= count_value - 32'h00000001;
        end
      end
      watchdog_irq <= (wr_clear ? 1'b0 : raw_irq) & irq_enable;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  // Read decode
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr[11:2])
      `WDT_OFF_RELOAD >> 2:     rd_word = reload_value;
      `WDT_OFF_COUNT >> 2:      rd_word = count_value;
      `WDT_OFF_CONTROL >> 2:    rd_word = {30'h00000000, reset_output_enable, irq_enable};
      `WDT_OFF_IRQ_CLEAR >> 2:  rd_word = 32'h00000000;
      `WDT_OFF_RAW_IRQ >> 2:    rd_word = {31'h00000000, raw_irq};
      `WDT_OFF_MASKED_IRQ >> 2: rd_word = {31'h00000000, raw_irq & irq_enable};
      `WDT_OFF_STALL >> 2:      rd_word = {23'h000000, stall_enable, 8'h00};
      `WDT_OFF_LOCK >> 2:       rd_word = locked ? `WDT_LOCKED_READ : `WDT_UNLOCKED_READ;
      `WDT_OFF_PID4 >> 2:       rd_word = PID4;
      `WDT_OFF_PID5 >> 2:       rd_word = PID5;
      `WDT_OFF_PID6 >> 2:       rd_word = PID6;
      `WDT_OFF_PID7 >> 2:       rd_word = PID7;
      `WDT_OFF_PID0 >> 2:       rd_word = PID0;
      `WDT_OFF_PID1 >> 2:       rd_word = PID1;
      `WDT_OFF_PID2 >> 2:       rd_word = PID2;
      `WDT_OFF_PID3 >> 2:       rd_word = PID3;
      `WDT_OFF_CID0 >> 2:       rd_word = CID0;
      `WDT_OFF_CID1 >> 2:       rd_word = CID1;
      `WDT_OFF_CID2 >> 2:       rd_word = CID2;
      `WDT_OFF_CID3 >> 2:       rd_word = CID3;
      default: begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // One read at a time, data one cycle after address
  // Read data held stable until the master takes it
  // Address ready returns the cycle after the data handshake
  // Hazard avoided: live counter captured once, not tracked
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `WDT_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // wdt_top

// File: wdt_regs.vh
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
// Register byte offsets (12-bit)
`define WDT_OFF_RELOAD     12'h000
`define WDT_OFF_COUNT      12'h004
`define WDT_OFF_CONTROL    12'h008
`define WDT_OFF_IRQ_CLEAR  12'h00C
`define WDT_OFF_RAW_IRQ    12'h010
`define WDT_OFF_MASKED_IRQ 12'h014
`define WDT_OFF_STALL      12'h418
`define WDT_OFF_LOCK       12'hC00
`define WDT_OFF_PID4       12'hFD0
`define WDT_OFF_PID5       12'hFD4
`define WDT_OFF_PID6       12'hFD8
`define WDT_OFF_PID7       12'hFDC
`define WDT_OFF_PID0       12'hFE0
`define WDT_OFF_PID1       12'hFE4
`define WDT_OFF_PID2       12'hFE8
`define WDT_OFF_PID3       12'hFEC
`define WDT_OFF_CID0       12'hFF0
`define WDT_OFF_CID1       12'hFF4
`define WDT_OFF_CID2       12'hFF8
`define WDT_OFF_CID3       12'hFFC
// Field positions
`define WDT_CTL_IRQ_EN_BIT 0
`define WDT_CTL_RST_EN_BIT 1
`define WDT_STALL_BIT      8
// Reset values and keys
`define WDT_RELOAD_RESET   32'h0FFFFFFF
`define WDT_UNLOCK_KEY     32'h1ACCE551
`define WDT_LOCKED_READ    32'h00000001
`define WDT_UNLOCKED_READ  32'h00000000
// Bus responses
`define WDT_RESP_OKAY      2'h0
`define WDT_RESP_SLVERR    2'h2
`endif

// File: wdt_chk_assertions.sv
`timescale 1ns/1ps
// ********
// Watchdog port checks
// ********
module wdt_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Watchdog outputs
  input wire watchdog_irq,
  input wire watchdog_reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus handshake timing
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready high during write response");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  chk_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high during read data");
  chk_r_done: assert property (s_axi_rvalid && s_axi_rready |-> ##1 !s_axi_rvalid ##0 s_axi_arready)
    else $error("read data not retired");
  // Watchdog outputs
  chk_rst_sticky: assert property (watchdog_reset |=> watchdog_reset)
    else $error("system reset dropped");
  chk_rst_cause: assert property ($rose(watchdog_reset) |-> watchdog_irq)
    else $error("system reset without pending interrupt");
  chk_irq_clear: assert property ($fell(watchdog_irq) |-> s_axi_bvalid)
    else $error("interrupt fell without a write");
endmodule // wdt_chk

bind wdt_top wdt_chk i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .watchdog_irq(watchdog_irq), .watchdog_reset(watchdog_reset));

// File: wdt_host_model.sv
`timescale 1ns/1ps
// ********
// Debug halt source and reset sink
// ********
module wdt_host_model (
  // Clock
  input  wire aclk,
  // Bench control
  input  wire halt_req,
  // Device pins
  input  wire watchdog_reset,
  output reg  cpu_halted,
  output reg  reset_seen
);
  initial cpu_halted = 1'h0;
  initial reset_seen = 1'h0;
  // Halt follows request, reset is remembered
  always @(posedge aclk) begin
    cpu_halted <= halt_req;
    if (watchdog_reset) reset_seen <= 1'h1;
  end
endmodule // wdt_host_model

// File: tb_top.sv
`timescale 1ns/1ps
`include "wdt_regs.vh"
// ********
// Watchdog bench
// ********
module tb_top;
  reg         aclk = 1'h0, aresetn = 1'h0, halt_req = 1'h0;
  reg  [11:0] awaddr = 12'h0, araddr = 12'h0;
  reg  [31:0] wdata = 32'h0, d, c1;
  reg  [3:0]  wstrb = 4'hF;
  reg         awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
  reg  [1:0]  r;
  wire [31:0] rdata;
  wire [1:0]  bresp, rresp;
  wire        awready, wready, bvalid, arready, rvalid, cpu_halted, irq, wrst, reset_seen;
  integer     bad_count = 0, comparisons = 0;

  always #5 aclk = ~aclk;

  wdt_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_halted(cpu_halted), .watchdog_irq(irq), .watchdog_reset(wrst));
  wdt_host_model i_host (.aclk(aclk), .halt_req(halt_req), .watchdog_reset(wrst),
    .cpu_halted(cpu_halted), .reset_seen(reset_seen));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus write, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    chk(32'(bresp), 32'(er), "bresp");
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(d, e, nm);
  endtask

  task automatic wait_for(input bit rs, input int lim);
    repeat (lim) if ((rs ? reset_seen : irq) !== 1'h1) @(posedge aclk);
    chk(32'(rs ? reset_seen : irq), 32'h1, "output");
  endtask

  task do_reset;
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  task give_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Reset values and refused accesses
  task s_regs;
    rc(`WDT_OFF_RELOAD, `WDT_RELOAD_RESET, "reload");
    rc(`WDT_OFF_COUNT, `WDT_RELOAD_RESET, "count");
    rc(`WDT_OFF_LOCK, `WDT_UNLOCKED_READ, "lock");
    rc(`WDT_OFF_CONTROL, 32'h0, "ctl");
    rd(12'h020);
    chk(32'(r), 32'(`WDT_RESP_SLVERR), "rresp");
    wr(`WDT_OFF_COUNT, 32'h5, `WDT_RESP_SLVERR);
  endtask

  // Lock and unlock
  task s_lock;
    wr(`WDT_OFF_LOCK, 32'h0, `WDT_RESP_OKAY);
    rc(`WDT_OFF_LOCK, `WDT_LOCKED_READ, "lock");
    wr(`WDT_OFF_RELOAD, 32'h5, `WDT_RESP_OKAY);
    rc(`WDT_OFF_RELOAD, `WDT_RELOAD_RESET, "reload");
    wr(`WDT_OFF_LOCK, `WDT_UNLOCK_KEY, `WDT_RESP_OKAY);
    rc(`WDT_OFF_LOCK, `WDT_UNLOCKED_READ, "lock");
  endtask

  // Reload, zero reload and clear
  task s_reload;
    wr(`WDT_OFF_RELOAD, 32'h0, `WDT_RESP_OKAY);
    rc(`WDT_OFF_RAW_IRQ, 32'h1, "raw");
    rc(`WDT_OFF_MASKED_IRQ, 32'h0, "masked");
    wr(`WDT_OFF_RELOAD, 32'h28, `WDT_RESP_OKAY);
    rc(`WDT_OFF_COUNT, 32'h28, "count");
    rc(`WDT_OFF_RAW_IRQ, 32'h1, "raw");
    wr(`WDT_OFF_IRQ_CLEAR, 32'hA5A5A5A5, `WDT_RESP_OKAY);
    rc(`WDT_OFF_RAW_IRQ, 32'h0, "raw");
  endtask

  // Two time-outs with reset enabled
  task s_timeout;
    wr(`WDT_OFF_RELOAD, 32'h1E, `WDT_RESP_OKAY);
    wr(`WDT_OFF_CONTROL, 32'h3, `WDT_RESP_OKAY);
    wait_for(1'h0, 80);
    rc(`WDT_OFF_MASKED_IRQ, 32'h1, "masked");
    wr(`WDT_OFF_CONTROL, 32'h0, `WDT_RESP_OKAY);
    rc(`WDT_OFF_CONTROL, 32'h3, "ctl");
    wait_for(1'h1, 80);
  endtask

  // Time-out with reset disabled
  task s_noreset;
    do_reset;
    wr(`WDT_OFF_RELOAD, 32'hA, `WDT_RESP_OKAY);
    wr(`WDT_OFF_CONTROL, 32'h1, `WDT_RESP_OKAY);
    wait_for(1'h0, 40);
    repeat (40) @(posedge aclk);
    chk(32'(wrst), 32'h0, "reset");
  endtask

  // Counting stalls while halted
  task s_stall;
    do_reset;
    wr(`WDT_OFF_STALL, 32'h100, `WDT_RESP_OKAY);
    rc(`WDT_OFF_STALL, 32'h100, "stall");
    wr(`WDT_OFF_RELOAD, 32'h1F4, `WDT_RESP_OKAY);
    wr(`WDT_OFF_CONTROL, 32'h1, `WDT_RESP_OKAY);
    halt_req <= 1'h1;
    repeat (6) @(posedge aclk);
    rd(`WDT_OFF_COUNT);
    c1 = d;
    repeat (20) @(posedge aclk);
    rc(`WDT_OFF_COUNT, c1, "count");
    halt_req <= 1'h0;
    repeat (6) @(posedge aclk);
    rd(`WDT_OFF_COUNT);
    chk(32'(d < c1), 32'h1, "count");
  endtask

  initial begin
    do_reset;
    s_regs;
    s_lock;
    s_reload;
    s_timeout;
    s_noreset;
    s_stall;
    give_verdict;
  end

  // Hang guard
  initial begin
    #20000;
    bad_count++;
    give_verdict;
  end
endmodule // tb_top
